// >>> include/gpie_regs.vh
// Register map, field positions and reset values of the GPIO pin interrupt enable block
`ifndef GPIE_REGS_VH
`define GPIE_REGS_VH

`define GPIE_ADDR_W          8
`define GPIE_OFF_P0_EN       8'h00
`define GPIE_OFF_P1_EN       8'h04
`define GPIE_OFF_P2_EN       8'h08
`define GPIE_OFF_P3_EN       8'h0C
`define GPIE_OFF_CTRL        8'h10
`define GPIE_OFF_STATUS      8'h14
`define GPIE_OFF_MASK        8'h18
`define GPIE_OFF_PINS        8'h1C

`define GPIE_P0_VALID        8'hFF
`define GPIE_P1_VALID        8'hF7
`define GPIE_P2_VALID        8'hF8
`define GPIE_P3_VALID        8'h03
`define GPIE_EN_RESET        8'h00

`define GPIE_CTRL_CFG_LSB    0
`define GPIE_CTRL_GLOBAL_BIT 8
`define GPIE_CTRL_SENSE_BIT  9
`define GPIE_CTRL_PHP_BIT    10
`define GPIE_CTRL_RESET      32'h00000000

`define GPIE_STAT_GPIO_BIT   0
`define GPIE_STAT_W          1

`define GPIE_CFG_RISE        2'h0
`define GPIE_CFG_FALL_Z      2'h1
`define GPIE_CFG_PUSHPULL    2'h2
`define GPIE_CFG_FALL_RES    2'h3

`define GPIE_RESP_OKAY       2'h0
`define GPIE_RESP_SLVERR     2'h2

`endif

// >>> rtl/gpie_edge.v
// Pin synchroniser and per-pin edge qualifier for one eight-pin port
`timescale 1ns/1ns
`default_nettype none
`include "gpie_regs.vh"

module gpie_edge (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire [7:0] pin_in,
	input  wire [7:0] pin_enable,
	input  wire [1:0] port_cfg,
	output reg  [7:0] pin_event,
	output reg  [7:0] pin_level
);

	reg  [7:0] sync_a;
	reg  [7:0] sync_b;
	reg  [7:0] prev;
	wire [7:0] rise;
	wire [7:0] fall;
	reg  [7:0] next_event;

	assign rise = sync_b & ~prev;
	assign fall = ~sync_b & prev;

	always @* begin
		case (port_cfg)
			`GPIE_CFG_RISE:     next_event = rise;
			`GPIE_CFG_FALL_Z:   next_event = fall;
			`GPIE_CFG_FALL_RES: next_event = fall;
			default:            next_event = 8'h00;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			sync_a    <= 8'h00;
			sync_b    <= 8'h00;
			prev      <= 8'h00;
			pin_event <= 8'h00;
			pin_level <= 8'h00;
		end else begin
			sync_a    <= pin_in;
			sync_b    <= sync_a;
			prev      <= sync_b;
			pin_level <= sync_b;
			pin_event <= next_event & pin_enable;
		end
	end

endmodule
`default_nettype wire

// >>> rtl/gpie_top.v
// GPIO pin interrupt enable block with AXI4-Lite register slave
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "gpie_regs.vh"

module gpie_top (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  port_zero_pins,
	input  wire [7:0]  port_one_pins,
	input  wire [7:0]  port_two_pins,
	input  wire [7:0]  port_three_pins,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         gpio_irq_req,
	output reg         irq
);

	reg  [7:0]  port0_pin_irq_enable;
	reg  [7:0]  port1_pin_irq_enable;
	reg  [7:0]  port2_pin_irq_enable;
	reg  [7:0]  port3_pin_irq_enable;
	reg  [7:0]  port_cfg;
	reg         global_gpio_enable;
	reg         irq_enable_sense;
	reg         parallel_host_port_mode;
	reg  [0:0]  irq_status;
	reg  [0:0]  irq_mask;

	reg         aw_held;
	reg         w_held;
	reg  [7:0]  aw_addr;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;

	wire [7:0]  ev0;
	wire [7:0]  ev1;
	wire [7:0]  ev2;
	wire [7:0]  ev3;
	wire [7:0]  lv0;
	wire [7:0]  lv1;
	wire [7:0]  lv2;
	wire [7:0]  lv3;
	wire        any_event;
	wire        gpio_event;
	wire        do_write;
	wire        wr_hit;
	wire        wr_p0;
	wire        wr_p1;
	wire        wr_p2;
	wire        wr_p3;
	wire        wr_ctrl;
	wire        wr_mask;
	wire [0:0]  next_status;
	reg  [31:0] next_rdata;
	reg         next_rerr;

	// Byte lane 0 merge; upper lanes carry nothing in these registers
	// Reserved bits forced low so they can never enable a pin
	function [7:0] lane0;
		input [7:0] old;
		input [31:0] data;
		input [3:0] strb;
		input [7:0] valid;
		begin
			lane0 = (strb[0] ? data[7:0] : old) & valid;
		end
	endfunction

	// Offsets that answer OKAY
	function is_mapped;
		input [7:0] a;
		begin
			is_mapped = (a == `GPIE_OFF_P0_EN) || (a == `GPIE_OFF_P1_EN) ||
				(a == `GPIE_OFF_P2_EN) || (a == `GPIE_OFF_P3_EN) ||
				(a == `GPIE_OFF_CTRL) || (a == `GPIE_OFF_STATUS) ||
				(a == `GPIE_OFF_MASK) || (a == `GPIE_OFF_PINS);
		end
	endfunction

	// Pins reach the edge compare through two flops in each unit
	// one edge unit per port
	gpie_edge u_edge0 (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.pin_in     (port_zero_pins),
		.pin_enable (port0_pin_irq_enable),
		.port_cfg   (port_cfg[1:0]),
		.pin_event  (ev0),
		.pin_level  (lv0)
	);

	gpie_edge u_edge1 (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.pin_in     (port_one_pins),
		.pin_enable (port1_pin_irq_enable),
		.port_cfg   (port_cfg[3:2]),
		.pin_event  (ev1),
		.pin_level  (lv1)
	);

	gpie_edge u_edge2 (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.pin_in     (port_two_pins),
		.pin_enable (port2_pin_irq_enable),
		.port_cfg   (port_cfg[5:4]),
		.pin_event  (ev2),
		.pin_level  (lv2)
	);

	gpie_edge u_edge3 (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.pin_in     (port_three_pins),
		.pin_enable (port3_pin_irq_enable),
		.port_cfg   (port_cfg[7:6]),
		.pin_event  (ev3),
		.pin_level  (lv3)
	);

	// Gated after the edge units; a mode write takes hold next cycle
	// shared request
	assign any_event = |{ev0, ev1, ev2, ev3};
	assign gpio_event = any_event & global_gpio_enable & irq_enable_sense & ~parallel_host_port_mode;

	// Held off while a response stands, so one write at a time
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	// Write-one clear applies in the cycle the write is carried out
	assign wr_hit = do_write && (aw_addr == `GPIE_OFF_STATUS) && w_strb[0];
	// Set wins over a simultaneous write-one clear
	assign next_status = (irq_status & ~(wr_hit ? w_data[0:0] : 1'b0)) | gpio_event;

	// Write address side; ready pulses once per request
	// Address is held until the write is carried out
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			aw_held       <= 1'b0;
			aw_addr       <= 8'h00;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (do_write)
				aw_held <= 1'b0;
		end
	end

	// Write data side; taken before or after the address
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b0;
			w_held       <= 1'b0;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
		end else begin
			s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write)
				w_held <= 1'b0;
		end
	end

	// Response waits for both halves and stands until bready
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `GPIE_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= is_mapped(aw_addr) ? `GPIE_RESP_OKAY : `GPIE_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Register write strobes
	assign wr_p0   = do_write && (aw_addr == `GPIE_OFF_P0_EN);
	assign wr_p1   = do_write && (aw_addr == `GPIE_OFF_P1_EN);
	assign wr_p2   = do_write && (aw_addr == `GPIE_OFF_P2_EN);
	assign wr_p3   = do_write && (aw_addr == `GPIE_OFF_P3_EN);
	assign wr_ctrl = do_write && (aw_addr == `GPIE_OFF_CTRL);
	assign wr_mask = do_write && (aw_addr == `GPIE_OFF_MASK);

	always @(posedge aclk) begin
		if (!aresetn) begin
			port0_pin_irq_enable <= `GPIE_EN_RESET;
		end else if (wr_p0) begin
			port0_pin_irq_enable <= lane0(port0_pin_irq_enable, w_data, w_strb, `GPIE_P0_VALID);
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			port1_pin_irq_enable <= `GPIE_EN_RESET;
		end else if (wr_p1) begin
			port1_pin_irq_enable <= lane0(port1_pin_irq_enable, w_data, w_strb, `GPIE_P1_VALID);
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			port2_pin_irq_enable <= `GPIE_EN_RESET;
		end else if (wr_p2) begin
			port2_pin_irq_enable <= lane0(port2_pin_irq_enable, w_data, w_strb, `GPIE_P2_VALID);
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			port3_pin_irq_enable <= `GPIE_EN_RESET;
		end else if (wr_p3) begin
			port3_pin_irq_enable <= lane0(port3_pin_irq_enable, w_data, w_strb, `GPIE_P3_VALID);
		end
	end

	// Lane 0 holds the port edge config, lane 1 the enables and mode
	always @(posedge aclk) begin
		if (!aresetn) begin
			port_cfg                <= 8'h00;
			global_gpio_enable      <= 1'b0;
			irq_enable_sense        <= 1'b0;
			parallel_host_port_mode <= 1'b0;
		end else if (wr_ctrl) begin
			if (w_strb[0])
				port_cfg <= w_data[`GPIE_CTRL_CFG_LSB +: 8];
			if (w_strb[1]) begin
				global_gpio_enable      <= w_data[`GPIE_CTRL_GLOBAL_BIT];
				irq_enable_sense        <= w_data[`GPIE_CTRL_SENSE_BIT];
				parallel_host_port_mode <= w_data[`GPIE_CTRL_PHP_BIT];
			end
		end
	end

	// Mask gates only irq, never the shared request
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask <= 1'b0;
		end else if (wr_mask && w_strb[0]) begin
			irq_mask <= w_data[0:0];
		end
	end

	// Sticky status and interrupt outputs
	// Request pulse ignores the mask; only irq honours it
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_status   <= 1'b0;
			gpio_irq_req <= 1'b0;
			irq          <= 1'b0;
		end else begin
			irq_status   <= next_status;
			gpio_irq_req <= gpio_event;
			irq          <= |(next_status & irq_mask);
		end
	end

	// Enable registers are write-only; they read back as zero
	// Unmapped offsets answer SLVERR with zero data
	always @* begin
		next_rdata = 32'h00000000;
		next_rerr  = 1'b0;
		case (s_axi_araddr)
			`GPIE_OFF_P0_EN: next_rdata = 32'h00000000;
			`GPIE_OFF_P1_EN: next_rdata = 32'h00000000;
			`GPIE_OFF_P2_EN: next_rdata = 32'h00000000;
			`GPIE_OFF_P3_EN: next_rdata = 32'h00000000;
			`GPIE_OFF_CTRL: next_rdata = {21'h000000, parallel_host_port_mode, irq_enable_sense,
				global_gpio_enable, port_cfg};
			`GPIE_OFF_STATUS: next_rdata = {31'h00000000, irq_status};
			`GPIE_OFF_MASK: next_rdata = {31'h00000000, irq_mask};
			`GPIE_OFF_PINS: next_rdata = {lv3, lv2, lv1, lv0};
			default: next_rerr = 1'b1;
		endcase
	end

	// AXI read channel
	// Data captured at the address handshake, so it stands with rvalid
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `GPIE_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= next_rdata;
				s_axi_rresp  <= next_rerr ? `GPIE_RESP_SLVERR : `GPIE_RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// >>> test/gpie_asserts.sv
// Port-level checker for the GPIO pin interrupt enable block
`timescale 1ns/1ns
`default_nettype none
module gpie_asserts (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  port_zero_pins,
	input wire logic [7:0]  port_one_pins,
	input wire logic [7:0]  port_two_pins,
	input wire logic [7:0]  port_three_pins,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        gpio_irq_req,
	input wire logic        irq
);
	wire [31:0] pins = {port_three_pins, port_two_pins, port_one_pins, port_zero_pins};
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence rd_low_taken;
		s_axi_arvalid && s_axi_arready && (s_axi_araddr < 8'h10);
	endsequence
	reset_clear_a: assert property (disable iff (1'b0) !aresetn |=> !gpio_irq_req && !irq && !s_axi_rvalid)
		else $error("outputs not quiet after reset");
	edge_cause_a: assert property (gpio_irq_req |-> ($past(pins, 2) != $past(pins, 3))
		|| ($past(pins, 3) != $past(pins, 4)) || ($past(pins, 4) != $past(pins, 5)))
		else $error("request without a pin change");
	wo_read_a: assert property (rd_low_taken |=> s_axi_rdata == 32'h00000000)
		else $error("enable register read not zero");
	wr_latency_a: assert property (wr_taken |-> ##[2:4] s_axi_bvalid)
		else $error("write response late");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rd_latency_a: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read data late");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	resp_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
endmodule
bind gpie_top gpie_asserts gpie_asserts_inst (
	.aclk            (aclk),
	.aresetn         (aresetn),
	.port_zero_pins  (port_zero_pins),
	.port_one_pins   (port_one_pins),
	.port_two_pins   (port_two_pins),
	.port_three_pins (port_three_pins),
	.s_axi_awvalid   (s_axi_awvalid),
	.s_axi_awready   (s_axi_awready),
	.s_axi_bvalid    (s_axi_bvalid),
	.s_axi_bready    (s_axi_bready),
	.s_axi_bresp     (s_axi_bresp),
	.s_axi_araddr    (s_axi_araddr),
	.s_axi_arvalid   (s_axi_arvalid),
	.s_axi_arready   (s_axi_arready),
	.s_axi_rvalid    (s_axi_rvalid),
	.s_axi_rready    (s_axi_rready),
	.s_axi_rdata     (s_axi_rdata),
	.gpio_irq_req    (gpio_irq_req),
	.irq             (irq)
);
`default_nettype wire

// >>> test/gpie_pins_model.sv
// External pin drivers facing the four GPIO ports
`timescale 1ns/1ns
`default_nettype none
module gpie_pins_model (
	input  wire logic        aclk,
	input  wire logic [31:0] target,
	output var  logic [7:0]  pins_zero,
	output var  logic [7:0]  pins_one,
	output var  logic [7:0]  pins_two,
	output var  logic [7:0]  pins_three
);
	// 7 ns after the rising edge, early in the 20 ns cycle, so pins move clear of sampling
	always @(posedge aclk)
		{pins_three, pins_two, pins_one, pins_zero} <= #7 target;
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the GPIO pin interrupt enable block
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, target, pulses;
	logic [3:0]  wstrb;
	logic [31:0] gate [3] = '{32'h100, 32'h200, 32'h700};
	wire  [7:0]  p0, p1, p2, p3;
	wire         awready, wready, bvalid, arready, rvalid, req, irq;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	int          failures, n_checks, i;
	localparam [31:0] ON = 32'h300;
	gpie_pins_model gpie_pins_model_inst (.aclk(aclk), .target(target), .pins_zero(p0), .pins_one(p1),
		.pins_two(p2), .pins_three(p3));
	gpie_top gpie_top_inst (.aclk(aclk), .aresetn(aresetn), .port_zero_pins(p0), .port_one_pins(p1),
		.port_two_pins(p2), .port_three_pins(p3), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .gpio_irq_req(req), .irq(irq));
	initial begin
		aclk = 0;
		forever #10 aclk = ~aclk;
	end
	task chk(input string name, input [31:0] exp, input [31:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d, input [1:0] r);
		bit da, dw;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		da = 0;
		dw = 0;
		while (!(da && dw)) begin
			@(posedge aclk);
			if (awready) da = 1;
			if (wready) dw = 1;
			if (da) awvalid <= 0;
			if (dw) wvalid <= 0;
		end
		do @(posedge aclk); while (!bvalid);
		bready <= 0;
		chk("bresp", r, bresp);
	endtask
	task rd(input [7:0] a, input [31:0] e, input [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		while (!rvalid) @(posedge aclk);
		rready <= 0;
		chk("rresp", r, rresp);
		chk("rdata", e, rdata);
	endtask
	task pin(input [31:0] v, input [31:0] n);
		pulses = 0;
		@(posedge aclk);
		target <= v;
		repeat (8) begin
			@(posedge aclk);
			if (req === 1'b1) pulses++;
		end
		chk("pulses", n, pulses);
	endtask
	task end_of_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#400000;
		failures++;
		end_of_test;
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, target} = 0;
		pulses = 0;
		wstrb = 4'hF;
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		rd(8'h10, 0, 0);
		for (i = 0; i < 16; i += 4) rd(i[7:0], 0, 0);
		for (i = 0; i < 16; i += 4) wr(i[7:0], 32'hFF, 0);
		rd(8'h04, 0, 0);
		wr(8'h18, 1, 0);
		wr(8'h10, ON, 0);
		pin(32'h01, 1);
		chk("irq", 1, irq);
		wr(8'h14, 1, 0);
		rd(8'h14, 0, 0);
		chk("irq", 0, irq);
		pin(32'hFC070801, 0);
		pin(32'h03F8F701, 1);
		rd(8'h1C, 32'h03F8F701, 0);
		pin(0, 0);
		for (i = 0; i < 4; i++) begin
			wr(8'h10, ON | {24'h0, {4{i[1:0]}}}, 0);
			pin(32'h02, i == 0);
			pin(0, i == 1 || i == 3);
		end
		wr(8'h10, ON, 0);
		wr(8'h00, 32'hFD, 0);
		pin(32'h02, 0);
		pin(0, 0);
		for (i = 0; i < 3; i++) begin
			wr(8'h10, gate[i], 0);
			pin(32'h01, 0);
			pin(0, 0);
		end
		wr(8'h14, 1, 0);
		wr(8'h18, 0, 0);
		wr(8'h10, ON, 0);
		pin(32'h01, 1);
		chk("irq", 0, irq);
		rd(8'h14, 1, 0);
		wr(8'h18, 1, 0);
		rd(8'h18, 1, 0);
		chk("irq", 1, irq);
		wstrb <= 4'h0;
		wr(8'h18, 0, 0);
		wstrb <= 4'hF;
		rd(8'h18, 1, 0);
		rd(8'h20, 0, 2);
		wr(8'h24, 1, 2);
		@(posedge aclk);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		chk("irq", 0, irq);
		pin(0, 0);
		wr(8'h10, ON, 0);
		pin(32'h01, 0);
		end_of_test;
	end
endmodule
`default_nettype wire
